// [logic/ddr3_cmd_ctrl.sv]
// Controller end: drives one command per request onto the command link
`default_nettype none
module ddr3_cmd_ctrl
  import ddr3_cmd_pkg::*;
(
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_srst,
  // User request
  input  wire logic              i_req,
  input  wire logic [3:0]        i_pins,
  input  wire logic              i_cke,
  input  wire logic [BANK_W-1:0] i_ba,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DM_W-1:0]   i_dm,
  output logic                   o_busy,
  // Link
  ddr3_cmd_if.ctrl               link
);
  logic [3:0] pins; // Registered cs,ras,cas,we

  // Launch a request for one cycle, then return to deselect; cke holds
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pins      <= PIN_DES;
      link.cke  <= 1'b0;
      link.ba   <= '0;
      link.addr <= '0;
      link.dm   <= '0;
      o_busy    <= 1'b0;
    end else if (i_req && !o_busy) begin
      pins      <= i_pins;   // Caller keeps bank order and timing [RULE5] [RULE7]
      link.cke  <= i_cke;    // Passed through unchecked; caller keeps exit edges to NOP/DES [RULE16] [RULE2]
      link.ba   <= i_ba;
      link.addr <= i_addr;
      link.dm   <= i_dm;
      o_busy    <= 1'b1;
    end else begin
      pins      <= PIN_DES;  // Deselect between commands [RULE8]
      o_busy    <= 1'b0;
    end
  end

  assign link.cs_n  = pins[3];
  assign link.ras_n = pins[2];
  assign link.cas_n = pins[1];
  assign link.we_n  = pins[0];
endmodule
`default_nettype wire

// [logic/ddr3_cmd_dev.sv]
// Device end: samples the command link, decodes commands, tracks banks
//
// Contract
// RULE1 - Sample command pins at rising clock edge
// RULE2 - Decode using previous and current CKE
// RULE3 - Activate opens row in selected bank
// RULE4 - Row stays open until bank precharged
// RULE5 - Controller precharges before activating other row
// RULE6 - Precharge single bank or all via A10
// RULE7 - Bank idle for activate after tRP
// RULE8 - Other-bank access allowed during auto precharge
// RULE9 - Precharge to idle/precharging bank restarts tRP
// RULE10 - Write decode, auto precharge, chop on low
// RULE11 - Read decode, auto precharge, BL8 on high
// RULE12 - Fixed burst mode ignores A12
// RULE13 - Mode register set when all idle
// RULE14 - Refresh or self-refresh entry by CKE
// RULE15 - Power-down entry on NOP/DES, CKE falling
// RULE16 - Exit on NOP/DES with CKE rising
// RULE17 - ZQ calibration long or short via A10
// RULE18 - Byte lane masks act independently
// RULE19 - NOP registers no command
// RULE20 - Deselect ignores all other inputs
// RULE21 - Check bank state for activate/read/write
// RULE22 - Flag commands in wrong bank state
`default_nettype none
module ddr3_cmd_dev
  import ddr3_cmd_pkg::*;
#(
  parameter int TRP_CYCLES = TRP_CYC   // Precharge wait in clock cycles
)(
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_srst,
  // Burst configuration: on-the-fly enable and fixed chop
  input  wire logic                 i_otf_en,
  input  wire logic                 i_fixed_bc4,
  // Link
  ddr3_cmd_if.dev                   link,
  // Decoded command
  output cmd_type                   o_cmd,
  output logic                      o_cmd_valid,
  output logic [BANK_W-1:0]         o_bank,
  output logic [ADDR_W-1:0]         o_addr,
  output logic                      o_auto_pre,
  output logic                      o_bc4,
  output logic [DM_W-1:0]           o_lane_en,
  output logic                      o_illegal,
  // Device state
  output logic [NUM_BANKS-1:0]      o_bank_active,
  output logic [NUM_BANKS-1:0]      o_bank_busy,
  output logic                      o_power_down,
  output logic                      o_self_refresh
);
  logic                   cke_prev;                 // CKE one clock before
  bank_type               bank_st [NUM_BANKS];      // Per bank state
  logic [TRP_W-1:0]       trp_cnt [NUM_BANKS];      // Per bank precharge timer
  cmd_type                next_cmd;                 // Decoded command this edge
  logic                   all_idle;                 // No bank active or precharging
  logic                   next_illegal;             // Wrong bank state
  logic                   sel;                      // Chip selected

  // True when a bank may accept activate
  function automatic logic bank_ready(input bank_type st);
    return st == BANK_IDLE;
  endfunction

  // Previous CKE tracks the level registered on each edge [RULE2]
  always_ff @(posedge i_clk) begin
    if (i_srst) cke_prev <= 1'b0;
    else        cke_prev <= link.cke;
  end

  // All banks idle
  always_comb begin
    all_idle = 1'b1;
    for (int b = 0; b < NUM_BANKS; b++) begin
      if (bank_st[b] != BANK_IDLE) all_idle = 1'b0;
    end
  end

  // Command decode from pins and both CKE levels [RULE1] [RULE2]
  always_comb begin
    sel      = ~link.cs_n;
    next_cmd = CMD_NONE;
    if (cke_prev && link.cke) begin
      // Clock enable steady high: ordinary commands
      if (!sel) next_cmd = CMD_DES;                       // [RULE20]
      else begin
        case ({link.ras_n, link.cas_n, link.we_n})
          3'h7: next_cmd = CMD_NOP;                        // [RULE19]
          3'h3: next_cmd = CMD_ACT;                        // [RULE3]
          3'h2: next_cmd = link.addr[AP_BIT] ? CMD_PREA : CMD_PRE; // [RULE6]
          3'h4: next_cmd = CMD_WR;                         // [RULE10]
          3'h5: next_cmd = CMD_RD;                         // [RULE11]
          3'h0: next_cmd = CMD_MRS;                        // [RULE13]
          3'h1: next_cmd = CMD_REF;                        // [RULE14]
          3'h6: next_cmd = link.addr[AP_BIT] ? CMD_ZQL : CMD_ZQS; // [RULE17]
          default: next_cmd = CMD_NONE;
        endcase
      end
    end else if (cke_prev && !link.cke) begin
      // Clock enable falling: only power-down or self refresh entry
      if (!sel || {link.ras_n, link.cas_n, link.we_n} == 3'h7)
        next_cmd = CMD_PDE;                                // [RULE15]
      else if ({link.ras_n, link.cas_n, link.we_n} == 3'h1)
        next_cmd = CMD_SRE;                                // [RULE14]
    end else if (!cke_prev && link.cke) begin
      // Clock enable rising: leave whichever low power state is held
      if (!sel || {link.ras_n, link.cas_n, link.we_n} == 3'h7)
        next_cmd = o_self_refresh ? CMD_SRX : CMD_PDX;     // [RULE16]
    end
  end

  // Bank state check for the addressed bank, or every bank for MRS, refresh, self refresh and ZQ [RULE21] [RULE22]
  always_comb begin
    case (next_cmd)
      CMD_ACT:                   next_illegal = !bank_ready(bank_st[link.ba]);
      CMD_RD, CMD_WR:            next_illegal = bank_st[link.ba] != BANK_ACTIVE;
      // Commands that need every bank idle
      CMD_MRS, CMD_REF, CMD_SRE,
      CMD_ZQL, CMD_ZQS:          next_illegal = !all_idle;
      default:                   next_illegal = 1'b0;
    endcase
  end

  // Bank state tracking and precharge timers
  always_ff @(posedge i_clk) begin
    for (int b = 0; b < NUM_BANKS; b++) begin
      if (i_srst) begin
        // Every bank idle with its timer clear
        bank_st[b]  <= BANK_IDLE;
        trp_cnt[b]  <= '0;
      end else if ((next_cmd == CMD_PREA) ||
                   (next_cmd == CMD_PRE && link.ba == BANK_W'(b)) ||
                   ((next_cmd == CMD_RD || next_cmd == CMD_WR) && !next_illegal &&
                    link.ba == BANK_W'(b) && link.addr[AP_BIT])) begin
        // Any precharge restarts the wait, even on idle banks [RULE4] [RULE9] [RULE7]
        bank_st[b] <= BANK_PRECHARGING;
        trp_cnt[b] <= TRP_W'(TRP_CYCLES);
      end else if (next_cmd == CMD_ACT && !next_illegal && link.ba == BANK_W'(b)) begin
        // Illegal activates never reach here, so the bank keeps its state
        bank_st[b]  <= BANK_ACTIVE;                        // [RULE3]
      end else if (bank_st[b] == BANK_PRECHARGING) begin
        // Other banks keep running during auto precharge [RULE8]
        if (trp_cnt[b] <= TRP_W'(1)) begin
          bank_st[b] <= BANK_IDLE;                         // [RULE7]
          trp_cnt[b] <= '0;
        end else trp_cnt[b] <= trp_cnt[b] - TRP_W'(1);
      end
    end
  end

  // Power-down and self-refresh status
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_power_down   <= 1'b0;
      o_self_refresh <= 1'b0;
    end else begin
      if (next_cmd == CMD_PDE) o_power_down <= 1'b1;       // [RULE15]
      else if (next_cmd == CMD_PDX) o_power_down <= 1'b0;  // [RULE16]
      // Self refresh only starts with every bank idle
      if (next_cmd == CMD_SRE && all_idle) o_self_refresh <= 1'b1; // [RULE14]
      else if (next_cmd == CMD_SRX) o_self_refresh <= 1'b0;        // [RULE16]
    end
  end

  // Registered command outputs
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_cmd       <= CMD_NONE;
      o_cmd_valid <= 1'b0;
      o_bank      <= '0;
      o_addr      <= '0;
      o_auto_pre  <= 1'b0;
      o_bc4       <= 1'b0;
      o_lane_en   <= '0;
      o_illegal   <= 1'b0;
    end else begin
      o_cmd       <= next_cmd;
      // NOP and deselect register nothing [RULE19] [RULE20]
      o_cmd_valid <= !(next_cmd inside {CMD_NONE, CMD_NOP, CMD_DES}) && !next_illegal;
      o_bank      <= link.ba;
      o_addr      <= link.addr;
      o_auto_pre  <= (next_cmd == CMD_RD || next_cmd == CMD_WR) && link.addr[AP_BIT];
      // Chop: A12 low on the fly, else fixed setting [RULE10] [RULE11] [RULE12]
      o_bc4       <= i_otf_en ? !link.addr[BC_BIT] : i_fixed_bc4;
      // Each lane written unless its mask is high [RULE18]
      o_lane_en   <= (next_cmd == CMD_WR && !next_illegal) ? ~link.dm : '0;
      o_illegal   <= next_illegal;                         // [RULE22]
    end
  end

  // Bank status vectors
  always_ff @(posedge i_clk) begin
    for (int b = 0; b < NUM_BANKS; b++) begin
      if (i_srst) begin
        o_bank_active[b] <= 1'b0;
        o_bank_busy[b]   <= 1'b0;
      end else begin
        // Registered copies so the outputs come straight from flip-flops
        o_bank_active[b] <= bank_st[b] == BANK_ACTIVE;
        o_bank_busy[b]   <= bank_st[b] == BANK_PRECHARGING;
      end
    end
  end
endmodule
`default_nettype wire

// [logic/ddr3_cmd_if.sv]
// Command link between controller and device ends
`default_nettype none
interface ddr3_cmd_if;
  import ddr3_cmd_pkg::*;
  logic              cs_n;   // Chip select, low active
  logic              ras_n;  // Row strobe, low active
  logic              cas_n;  // Column strobe, low active
  logic              we_n;   // Write enable, low active
  logic              cke;    // Clock enable
  logic [BANK_W-1:0] ba;     // Bank select
  logic [ADDR_W-1:0] addr;   // Address
  logic [DM_W-1:0]   dm;     // Write data mask
  modport ctrl (output cs_n, ras_n, cas_n, we_n, cke, ba, addr, dm);
  modport dev  (input  cs_n, ras_n, cas_n, we_n, cke, ba, addr, dm);
endinterface
`default_nettype wire

// [logic/ddr3_cmd_pkg.sv]
// Constants and types shared by the controller and device ends of the command link
`default_nettype none
package ddr3_cmd_pkg;
  localparam int BANK_W      = 3;           // Bank select width
  localparam int NUM_BANKS   = 8;           // Banks tracked
  localparam int ADDR_W      = 15;          // Row/column/opcode address width
  localparam int DM_W        = 2;           // Byte lane mask width
  localparam int AP_BIT      = 10;          // Auto precharge / all banks / ZQ long bit
  localparam int BC_BIT      = 12;          // Burst chop select bit
  localparam int CLK_MHZ     = 50;          // System clock rate
  localparam int TRP_PS      = 13500;       // Row precharge time
  localparam int TRP_CYC_RAW = (TRP_PS * CLK_MHZ + 999999) / 1000000;
  localparam int TRP_CYC     = (TRP_CYC_RAW < 1) ? 1 : TRP_CYC_RAW; // Least time, rounded up
  localparam int TRP_W       = 8;           // Width of per-bank precharge timer
  localparam logic [3:0] PIN_DES = 4'hf;    // Idle pin levels cs,ras,cas,we

  // Decoded command kinds
  typedef enum logic [3:0] {
    CMD_NONE, CMD_DES, CMD_NOP, CMD_ACT, CMD_PRE, CMD_PREA, CMD_WR, CMD_RD,
    CMD_MRS, CMD_REF, CMD_SRE, CMD_SRX, CMD_PDE, CMD_PDX, CMD_ZQL, CMD_ZQS
  } cmd_type;

  // Per bank state
  typedef enum logic [1:0] {
    BANK_IDLE, BANK_ACTIVE, BANK_PRECHARGING
  } bank_type;
endpackage
`default_nettype wire

// [testbench/ddr3_cmd_chk.sv]
// Checks on the command link and the device end's decoded outputs
`default_nettype none
module ddr3_cmd_chk
  import ddr3_cmd_pkg::*;
(
  // Clock and reset
  input wire logic                 i_clk,
  input wire logic                 i_srst,
  // Link pins
  input wire logic                 cs_n,
  input wire logic                 ras_n,
  input wire logic                 cas_n,
  input wire logic                 we_n,
  input wire logic                 cke,
  input wire logic [BANK_W-1:0]    ba,
  input wire logic [ADDR_W-1:0]    addr,
  // Device outputs
  input wire logic                 o_cmd_valid,
  input wire logic                 o_illegal,
  input wire logic [NUM_BANKS-1:0] o_bank_active,
  input wire logic [NUM_BANKS-1:0] o_bank_busy,
  input wire logic                 o_power_down,
  input wire logic                 o_self_refresh
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  wire logic [3:0] pins = {cs_n, ras_n, cas_n, we_n};         // Command pin group
  wire logic       idle = ~|(o_bank_active | o_bank_busy);   // No bank open or closing
  // Clock enable high now and one cycle before
  sequence s_run; cke && $past(cke); endsequence
  // Deselect or no-operation
  sequence s_quiet; cs_n || pins == 4'h7; endsequence
  // Activate accepted, then the bank reads open
  sequence s_opened; o_cmd_valid ##1 o_bank_active[$past(ba, 2)]; endsequence
  property p_open;
    s_run ##0 (pins == 4'h3 && !o_bank_active[ba] && !o_bank_busy[ba]) |=> s_opened;
  endproperty
  a_open: assert property (p_open) else $error("activate did not open its bank");
  property p_act_bad; s_run ##0 (pins == 4'h3 && o_bank_active[ba]) |=> o_illegal; endproperty
  a_act_bad: assert property (p_act_bad) else $error("activate on open bank taken");
  property p_rw_bad;
    s_run ##0 (pins[3:1] == 3'b010 && !o_bank_active[ba]) |=> o_illegal;
  endproperty
  a_rw_bad: assert property (p_rw_bad) else $error("access to closed bank taken");
  property p_prea;
    s_run ##0 (pins == 4'h2 && addr[AP_BIT]) |=> o_cmd_valid ##1 o_bank_active == '0;
  endproperty
  a_prea: assert property (p_prea) else $error("all-bank precharge left a row open");
  property p_quiet;
    s_run ##0 s_quiet |=> !o_illegal && $stable(o_power_down) && $stable(o_self_refresh);
  endproperty
  a_quiet: assert property (p_quiet) else $error("idle cycle changed device state");
  property p_pde; $fell(cke) ##0 s_quiet |=> o_power_down; endproperty
  a_pde: assert property (p_pde) else $error("power-down not entered");
  property p_sre; $fell(cke) ##0 (pins == 4'h1 && idle) |=> o_self_refresh; endproperty
  a_sre: assert property (p_sre) else $error("self refresh not entered");
  property p_wake; $rose(cke) ##0 s_quiet |=> !o_power_down && !o_self_refresh; endproperty
  a_wake: assert property (p_wake) else $error("low power state not left");
endmodule
`default_nettype wire

// [testbench/test_ddr3_command_decoder.sv]
// Self-checking bench for the two ends joined on one command link
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module test_ddr3_command_decoder
  import ddr3_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0, i_srst = 1'b1, req = 1'b0, cke = 1'b0, otf = 1'b1, fbc4 = 1'b0;
  logic [3:0]           pins = PIN_DES;              // Requested pin levels
  logic [BANK_W-1:0]    ba = '0;                     // Requested bank
  logic [ADDR_W-1:0]    addr = '0;                   // Requested address
  logic [DM_W-1:0]      dm = '0, lane, got_lane;     // Masks and lanes seen
  logic [BANK_W-1:0]    obank, got_bank;             // Decoded bank
  logic [ADDR_W-1:0]    oaddr, got_addr;             // Decoded row, column or opcode
  logic [NUM_BANKS-1:0] bact, bbusy;                 // Bank state
  logic busy, cv, ill, ap, bc4, pd, sr, got_ill, got_ap, got_bc4;
  cmd_type              ocmd, got;                   // Decoded and captured command
  int bad_count = 0, checks = 0, cyc = 0;
  ddr3_cmd_if ddr3_cmd_if_i ();
  ddr3_cmd_ctrl ddr3_cmd_ctrl_i (.i_clk(i_clk), .i_srst(i_srst), .i_req(req), .i_pins(pins),
    .i_cke(cke), .i_ba(ba), .i_addr(addr), .i_dm(dm), .o_busy(busy), .link(ddr3_cmd_if_i));
  ddr3_cmd_dev #(.TRP_CYCLES(8)) ddr3_cmd_dev_i (.i_clk(i_clk), .i_srst(i_srst),
    .i_otf_en(otf), .i_fixed_bc4(fbc4), .link(ddr3_cmd_if_i), .o_cmd(ocmd), .o_cmd_valid(cv),
    .o_bank(obank), .o_addr(oaddr), .o_auto_pre(ap), .o_bc4(bc4), .o_lane_en(lane),
    .o_illegal(ill), .o_bank_active(bact), .o_bank_busy(bbusy), .o_power_down(pd),
    .o_self_refresh(sr));
  ddr3_cmd_chk ddr3_cmd_chk_i (.i_clk(i_clk), .i_srst(i_srst), .cs_n(ddr3_cmd_if_i.cs_n),
    .ras_n(ddr3_cmd_if_i.ras_n), .cas_n(ddr3_cmd_if_i.cas_n), .we_n(ddr3_cmd_if_i.we_n),
    .cke(ddr3_cmd_if_i.cke), .ba(ddr3_cmd_if_i.ba), .addr(ddr3_cmd_if_i.addr),
    .o_cmd_valid(cv), .o_illegal(ill), .o_bank_active(bact), .o_bank_busy(bbusy),
    .o_power_down(pd), .o_self_refresh(sr));
  always #10 i_clk = ~i_clk;
  // Capture decoder pulses and cut a hang short
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cv) begin
      got <= ocmd;
      got_ap <= ap;
      got_bc4 <= bc4;
      got_lane <= lane;
      got_bank <= obank;
      got_addr <= oaddr;
    end
    if (ill) got_ill <= 1'b1;
    if (cyc == 3000) begin
      bad_count++;
      test_done();
    end
  end
  // One request, then the decode is judged; CMD_DES skips the judgement
  task automatic cmd(input logic [3:0] p, input logic k, input logic [BANK_W-1:0] b,
                     input logic [ADDR_W-1:0] a, input logic [DM_W-1:0] m, input cmd_type e);
    @(posedge i_clk);
    got = CMD_NONE;
    got_ill = 1'b0;
    req <= 1'b1;
    pins <= p;
    cke <= k;
    ba <= b;
    addr <= a;
    dm <= m;
    @(posedge i_clk);
    req <= 1'b0;
    @(posedge i_clk);
    `CHK("busy", 1'b1, busy)
    repeat (3) @(posedge i_clk);
    if (e != CMD_DES) begin
      `CHK("command", e, got)
      `CHK("illegal", e == CMD_NONE, got_ill)
    end
  endtask
  task automatic t_rw;
    cmd(4'h3, 1'b1, 3'h4, 15'h0055, 2'h0, CMD_ACT);
    cmd(4'h3, 1'b1, 3'h2, 15'h0123, 2'h0, CMD_ACT);
    `CHK("bank", 3'h2, got_bank)
    `CHK("row", 15'h0123, got_addr)
    cmd(4'h4, 1'b1, 3'h2, 15'h0000, 2'h1, CMD_WR);
    `CHK("chop", 1'b1, got_bc4)
    `CHK("lanes", 2'h2, got_lane)
    cmd(4'h5, 1'b1, 3'h2, 15'h1000, 2'h0, CMD_RD);
    `CHK("full burst", 1'b0, got_bc4)
    otf <= 1'b0;
    fbc4 <= 1'b1;
    cmd(4'h5, 1'b1, 3'h2, 15'h1400, 2'h0, CMD_RD);
    `CHK("fixed chop", 1'b1, got_bc4)
    `CHK("auto pre", 1'b1, got_ap)
    `CHK("closed", 1'b0, bact[2])
    otf <= 1'b1;
    fbc4 <= 1'b0;
    // Bank 2 is still closing while the other open bank is written
    cmd(4'h4, 1'b1, 3'h4, 15'h0000, 2'h2, CMD_WR);
    `CHK("other lane", 2'h1, got_lane)
    $display("t_rw done");
  endtask
  task automatic t_bad;
    cmd(4'h5, 1'b1, 3'h5, '0, 2'h0, CMD_NONE);
    cmd(4'h3, 1'b1, 3'h3, '0, 2'h0, CMD_ACT);
    cmd(4'h3, 1'b1, 3'h3, '0, 2'h0, CMD_NONE);
    cmd(4'h0, 1'b1, 3'h0, '0, 2'h0, CMD_NONE);
    cmd(4'h2, 1'b1, 3'h0, 15'h0400, 2'h0, CMD_PREA);
    `CHK("all closing", 8'hff, bbusy)
    repeat (8) @(posedge i_clk);
    `CHK("all idle", 8'h00, bbusy)
    cmd(4'h0, 1'b1, 3'h2, 15'h0010, 2'h0, CMD_MRS);
    `CHK("opcode", 15'h0010, got_addr)
    `CHK("register", 3'h2, got_bank)
    cmd(4'h6, 1'b1, 3'h0, 15'h0400, 2'h0, CMD_ZQL);
    cmd(4'h6, 1'b1, 3'h0, 15'h0000, 2'h0, CMD_ZQS);
    cmd(4'h1, 1'b1, 3'h0, '0, 2'h0, CMD_REF);
    $display("t_bad done");
  endtask
  task automatic t_pre;
    cmd(4'h3, 1'b1, 3'h1, '0, 2'h0, CMD_ACT);
    cmd(4'h2, 1'b1, 3'h1, '0, 2'h0, CMD_PRE);
    cmd(4'h2, 1'b1, 3'h1, '0, 2'h0, CMD_PRE);
    // One more edge: without the restart the first wait would have ended two edges earlier
    @(posedge i_clk);
    `CHK("restarted", 1'b1, bbusy[1])
    cmd(4'h3, 1'b1, 3'h1, '0, 2'h0, CMD_NONE);
    $display("t_pre done");
  endtask
  task automatic t_pwr;
    cmd(4'hf, 1'b0, '0, '0, 2'h0, CMD_DES);
    `CHK("power down", 1'b1, pd)
    cmd(4'hf, 1'b1, '0, '0, 2'h0, CMD_DES);
    `CHK("awake", 1'b0, pd)
    cmd(4'h1, 1'b0, '0, '0, 2'h0, CMD_DES);
    `CHK("self refresh", 1'b1, sr)
    cmd(4'h7, 1'b1, '0, '0, 2'h0, CMD_DES);
    `CHK("refresh left", 1'b0, sr)
    $display("t_pwr done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge i_clk);
    i_srst <= 1'b0;
    cmd(4'h7, 1'b1, '0, '0, 2'h0, CMD_DES);
    t_rw();
    t_bad();
    t_pre();
    t_pwr();
    test_done();
  end
endmodule
`default_nettype wire
